// [hdl/user_flow_control_channel.sv]
// User flow control side channel: transmit sequencer, buffer and receive framer.
// Assumes user-side inputs synchronous to sys_clk and a lane that takes one
// block per cycle while linkReady is high.
//
// Summary of operation
// - Receive payload bus is 64 bits per lane
// - Last marks final word of each message
// - Final word keep: one bit per byte
// - In-progress flag low during reception
// - Regular ready low; message ready until complete
// - Idle blocks fill gaps in message valid
// - Higher-priority operations drop message ready
// - One header cycle with both readies low
// - One-word message: valid and last together
// - Size code is byte count minus one
// - Message ready two cycles after request
// - Partial final beat uses leftmost bytes
`timescale 1ns/10ps
`include "ufc_params.svh"

module user_flow_control_channel #(
  parameter int LANES = `UFC_LANES,
  parameter int FIFO_DEPTH = `UFC_FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock, 20 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic msgReq, // One-cycle message request
  input wire logic [`UFC_SIZE_W-1:0] msg_size_code, // Byte count minus one
  input wire logic [`UFC_LANE_BITS*LANES-1:0] txMsgData, // Message payload
  input wire logic txMsgValid, // Payload valid
  output logic txMsgReady, // Payload accepted when valid
  output logic regularDataReady, // Regular data may flow
  input wire logic clock_compensation, // Clock compensation in progress
  input wire logic channel_bonding, // Channel bonding in progress
  input wire logic nfcBusy, // Native flow control in progress
  input wire logic linkReady, // Lane takes a block this cycle
  output logic [1:0] txBlkKind, // Block kind offered to lane
  output logic [`UFC_LANE_BITS*LANES-1:0] txBlkData, // Block payload
  output logic [`UFC_LANE_BYTES*LANES-1:0] txBlkKeep, // Valid bytes of block
  output logic txBlkLast, // Final data block of message
  input wire logic rxHdrValid, // Received header block
  input wire logic [`UFC_SIZE_W-1:0] rxHdrSize, // Received size code
  input wire logic rxDataValid, // Received data block
  input wire logic [`UFC_LANE_BITS*LANES-1:0] rxData, // Received block payload
  output logic [`UFC_LANE_BITS*LANES-1:0] rxMsgData, // Receive payload
  output logic rxMsgValid, // Receive payload valid
  output logic rxMsgLast, // Receive final word
  output logic [`UFC_LANE_BYTES*LANES-1:0] rxMsgKeep, // Receive valid bytes
  output logic rxInProgressN // Low while receiving
);

  // ------------------------------------------------------------------
  // Widths and local types
  // ------------------------------------------------------------------

  localparam int DW = `UFC_LANE_BITS * LANES;
  localparam int KW = `UFC_LANE_BYTES * LANES;
  localparam int FW = DW + KW + 1;
  localparam logic [`UFC_COUNT_W-1:0] BUS_BYTES = `UFC_COUNT_W'(KW);

  typedef struct packed {
    ufc_pkg::tx_state_e state;
    logic [`UFC_COUNT_W-1:0] remBytes;
    logic [`UFC_SIZE_W-1:0] sizeCode;
    ufc_pkg::blk_kind_e kind;
    logic [DW-1:0] data;
    logic [KW-1:0] keep;
    logic last;
  } tx_s;

  tx_s tx_ff;
  tx_s nxt_tx;
  logic hiPri;
  logic accept;
  logic finalBeat;
  logic [KW-1:0] beatKeep;
  logic [KW-1:0] lastKeep;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [FW-1:0] fifoInData;
  logic [FW-1:0] fifoOutData;
  logic hdrSent;
  logic bypass;
  logic fifoInValid;

  // ------------------------------------------------------------------
  // Handshake terms
  // ------------------------------------------------------------------

  // Any higher-priority lane operation
  assign hiPri = clock_compensation || channel_bonding || nfcBusy;

  assign txMsgReady = (tx_ff.state == ufc_pkg::TX_DATA) && !hiPri && fifoInReady;

  assign regularDataReady = (tx_ff.state == ufc_pkg::TX_IDLE) && !msgReq && !hiPri
    && !fifoOutValid;

  assign accept = txMsgReady && txMsgValid;
  assign finalBeat = (tx_ff.remBytes <= BUS_BYTES);

  // Drain the buffer only when the lane takes a block for this channel
  assign fifoOutReady = linkReady && !hiPri;

  // Empty buffer and free lane: the beat goes straight out, no dead idle slot
  assign bypass = accept && !fifoOutValid && linkReady;
  assign fifoInValid = accept && !bypass;

  // Header leaves once older buffered data has gone
  assign hdrSent = (tx_ff.state == ufc_pkg::TX_HEADER) && linkReady && !hiPri
    && !fifoOutValid;

  // ------------------------------------------------------------------
  // Final beat byte selection
  // ------------------------------------------------------------------

  // Leftmost bytes of a partial final beat
  genvar i;
  generate
    for (i = 0; i < KW; i++)
    begin : g_keep
      assign lastKeep[i] = (int'(tx_ff.remBytes) + i >= KW);
    end
  endgenerate

  assign beatKeep = finalBeat ? lastKeep : '1;
  assign fifoInData = {finalBeat, beatKeep, txMsgData};

  // ------------------------------------------------------------------
  // Transmit sequencer and lane block register
  // ------------------------------------------------------------------

  // Next state of the sequencer and the block offered to the lane
  always_comb
  begin
    nxt_tx = tx_ff;
    unique case (tx_ff.state)
      ufc_pkg::TX_IDLE:
      begin
        if (msgReq)
        begin
          nxt_tx.sizeCode = msg_size_code;
          nxt_tx.remBytes = {1'b0, msg_size_code} + `UFC_SIZE_OFFSET;
          nxt_tx.state = ufc_pkg::TX_HEADER;
        end
      end
      ufc_pkg::TX_HEADER:
      begin
        if (hdrSent)
        begin
          nxt_tx.state = ufc_pkg::TX_DATA;
        end
      end
      ufc_pkg::TX_DATA:
      begin
        if (accept)
        begin
          if (finalBeat)
          begin
            nxt_tx.state = ufc_pkg::TX_IDLE;
          end
          else
          begin
            nxt_tx.remBytes = tx_ff.remBytes - BUS_BYTES;
          end
        end
      end
      default:
      begin
        nxt_tx.state = ufc_pkg::TX_IDLE;
      end
    endcase

    // Lane block chosen only on cycles the lane takes one
    if (linkReady)
    begin
      nxt_tx.data = '0;
      nxt_tx.keep = '0;
      nxt_tx.last = 1'b0;
      if (hiPri)
      begin
        nxt_tx.kind = ufc_pkg::BLK_NONE;
      end
      else if (fifoOutValid)
      begin
        nxt_tx.kind = ufc_pkg::BLK_DATA;
        nxt_tx.data = fifoOutData[DW-1:0];
        nxt_tx.keep = fifoOutData[DW+KW-1:DW];
        nxt_tx.last = fifoOutData[FW-1];
      end
      else if (bypass)
      begin
        nxt_tx.kind = ufc_pkg::BLK_DATA;
        nxt_tx.data = fifoInData[DW-1:0];
        nxt_tx.keep = fifoInData[DW+KW-1:DW];
        nxt_tx.last = fifoInData[FW-1];
      end
      else if (tx_ff.state == ufc_pkg::TX_HEADER)
      begin
        nxt_tx.kind = ufc_pkg::BLK_HEADER;
        nxt_tx.data = DW'(tx_ff.sizeCode);
      end
      else if (tx_ff.state == ufc_pkg::TX_DATA)
      begin
        nxt_tx.kind = ufc_pkg::BLK_IDLE;
      end
      else
      begin
        nxt_tx.kind = ufc_pkg::BLK_NONE;
      end
    end
  end

  // Sequencer register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_ff <= '0;
    end
    else
    begin
      tx_ff <= nxt_tx;
    end
  end

  assign txBlkKind = tx_ff.kind;
  assign txBlkData = tx_ff.data;
  assign txBlkKeep = tx_ff.keep;
  assign txBlkLast = tx_ff.last;

  // ------------------------------------------------------------------
  // Transmit payload buffer
  // ------------------------------------------------------------------

  // Accepted beats wait here while the lane is held off
  ufc_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inData(fifoInData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // ------------------------------------------------------------------
  // Receive framer
  // ------------------------------------------------------------------

  // Incoming header and data blocks become the receive stream
  ufc_rx_framer #(
    .LANES(LANES)
  ) u_rx_framer (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .rxHdrValid(rxHdrValid),
    .rxHdrSize(rxHdrSize),
    .rxDataValid(rxDataValid),
    .rxData(rxData),
    .rxMsgData(rxMsgData),
    .rxMsgValid(rxMsgValid),
    .rxMsgLast(rxMsgLast),
    .rxMsgKeep(rxMsgKeep),
    .rxInProgressN(rxInProgressN)
  );

endmodule

// [include/ufc_params.svh]
// Timing, width and sizing constants for the user flow control channel.
// Assumes inclusion by bare name from the package and from every design file.
`ifndef UFC_CHANNEL_PARAMS_SVH
`define UFC_CHANNEL_PARAMS_SVH

// Lane geometry
`define UFC_LANES 1
`define UFC_LANE_BITS 64
`define UFC_LANE_BYTES 8

// Message sizing
`define UFC_SIZE_W 8
`define UFC_COUNT_W 9
`define UFC_MAX_BYTES 256
`define UFC_SIZE_OFFSET 9'h001

// Transmit buffer depth in words
`define UFC_FIFO_DEPTH 8

`endif

// [include/ufc_pkg.sv]
// Shared types of the user flow control channel.
// Assumes nothing beyond the parameter header.
`include "ufc_params.svh"

package ufc_pkg;

  // Transmit sequencing states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HEADER = 2'b01,
    TX_DATA = 2'b10
  } tx_state_e;

  // Kind of block offered to the lane each cycle
  typedef enum logic [1:0] {
    BLK_NONE = 2'b00,
    BLK_HEADER = 2'b01,
    BLK_DATA = 2'b10,
    BLK_IDLE = 2'b11
  } blk_kind_e;

endpackage

// [hdl/ufc_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
`include "ufc_params.svh"

module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `UFC_FIFO_DEPTH
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] inData, // Write data
  input wire logic inValid, // Write request
  output logic inReady, // Not full
  output logic [WIDTH-1:0] outData, // Head word
  output logic outValid, // Not empty
  input wire logic outReady // Head consumed
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
  } fifo_s;

  fifo_s fifo_ff;
  fifo_s nxt_fifo;
  logic doWrite;
  logic doRead;

  // Honest flags straight from the fill count
  assign inReady = (fifo_ff.count != FULL_CNT);
  assign outValid = (fifo_ff.count != '0);
  assign outData = fifo_ff.mem[fifo_ff.rdPtr];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  // Pointer and count update with wrap at the last entry
  always_comb
  begin
    nxt_fifo = fifo_ff;
    if (doWrite)
    begin
      nxt_fifo.mem[fifo_ff.wrPtr] = inData;
      nxt_fifo.wrPtr = (fifo_ff.wrPtr == LAST_PTR) ? '0 : fifo_ff.wrPtr + 1'b1;
    end
    if (doRead)
    begin
      nxt_fifo.rdPtr = (fifo_ff.rdPtr == LAST_PTR) ? '0 : fifo_ff.rdPtr + 1'b1;
    end
    if (doWrite && !doRead)
    begin
      nxt_fifo.count = fifo_ff.count + 1'b1;
    end
    else if (doRead && !doWrite)
    begin
      nxt_fifo.count = fifo_ff.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_ff <= '0;
    end
    else
    begin
      fifo_ff <= nxt_fifo;
    end
  end

endmodule

// [hdl/ufc_rx_framer.sv]
// Receive side: turns decoded message header and data blocks into a stream.
// Assumes the lane decoder gives one header block before each message's data.
`timescale 1ns/10ps
`include "ufc_params.svh"

module ufc_rx_framer #(
  parameter int LANES = `UFC_LANES
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic rxHdrValid, // Message header block received
  input wire logic [`UFC_SIZE_W-1:0] rxHdrSize, // Size code carried by header
  input wire logic rxDataValid, // Message data block received
  input wire logic [`UFC_LANE_BITS*LANES-1:0] rxData, // Data block payload
  output logic [`UFC_LANE_BITS*LANES-1:0] rxMsgData, // Message payload word
  output logic rxMsgValid, // Payload word valid
  output logic rxMsgLast, // Final word of message
  output logic [`UFC_LANE_BYTES*LANES-1:0] rxMsgKeep, // Valid byte lanes
  output logic rxInProgressN // Low while a message arrives
);

  localparam int DW = `UFC_LANE_BITS * LANES;
  localparam int KW = `UFC_LANE_BYTES * LANES;
  localparam logic [`UFC_COUNT_W-1:0] BUS_BYTES = `UFC_COUNT_W'(KW);

  typedef struct packed {
    logic inProgN;
    logic [`UFC_COUNT_W-1:0] remBytes;
    logic [DW-1:0] data;
    logic [KW-1:0] keep;
    logic valid;
    logic last;
  } rx_s;

  localparam rx_s RX_RESET = '{inProgN: 1'b1, default: '0};

  rx_s rx_ff;
  rx_s nxt_rx;
  logic [KW-1:0] lastKeep;
  logic finalWord;

  // Left-justified keep for a partial final word
  genvar i;
  generate
    for (i = 0; i < KW; i++)
    begin : g_keep
      assign lastKeep[i] = (int'(rx_ff.remBytes) + i >= KW);
    end
  endgenerate

  assign finalWord = (rx_ff.remBytes <= BUS_BYTES);

  // Header opens a message, data words count it down
  always_comb
  begin
    nxt_rx = rx_ff;
    nxt_rx.valid = 1'b0;
    nxt_rx.last = 1'b0;
    if (rxHdrValid)
    begin
      nxt_rx.remBytes = {1'b0, rxHdrSize} + `UFC_SIZE_OFFSET;
      nxt_rx.inProgN = 1'b0;
    end
    else if (rxDataValid && !rx_ff.inProgN)
    begin
      nxt_rx.data = rxData;
      nxt_rx.valid = 1'b1;
      nxt_rx.last = finalWord;
      nxt_rx.keep = finalWord ? lastKeep : '1;
      if (finalWord)
      begin
        nxt_rx.inProgN = 1'b1;
      end
      else
      begin
        nxt_rx.remBytes = rx_ff.remBytes - BUS_BYTES;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_ff <= RX_RESET;
    end
    else
    begin
      rx_ff <= nxt_rx;
    end
  end

  assign rxMsgData = rx_ff.data;
  assign rxMsgValid = rx_ff.valid;
  assign rxMsgLast = rx_ff.last;
  assign rxMsgKeep = rx_ff.keep;
  assign rxInProgressN = rx_ff.inProgN;

endmodule

// [testbench/ufc_app_model.sv]
// Application stand-in: feeds message beats over valid/ready.
// Assumes go is raised with the request and held until done.
`timescale 1ns/10ps

module ufc_app_model (
  input wire logic sys_clk, // Clock
  input wire logic go, // Start a message
  input var int beats, // Beats to send
  input var int gapAt, // Beat preceded by one idle cycle
  input wire logic txMsgReady, // Design takes payload
  output logic txMsgValid, // Payload valid
  output logic [63:0] txMsgData, // Payload
  output logic done // All beats taken
);
  int n;

  // Beat loop, holds each beat until ready
  initial
  begin
    txMsgValid = 1'b0;
    txMsgData = 64'h0000_0000_0000_0000;
    done = 1'b0;
    forever
    begin
      wait (go === 1'b1);
      for (n = 0; n < beats; n++)
      begin
        if (n == gapAt)
        begin
          @(posedge sys_clk);
          #1;
        end
        txMsgValid = 1'b1;
        txMsgData = {8{8'(n + 1)}};
        do
          @(posedge sys_clk);
        while (txMsgReady !== 1'b1);
        #1;
        if (n + 1 == beats || n + 1 == gapAt)
        begin
          txMsgValid = 1'b0;
          txMsgData = ~txMsgData;
        end
      end
      done = 1'b1;
      wait (go === 1'b0);
      done = 1'b0;
    end
  end
endmodule

// [testbench/user_flow_control_channel_sva.sv]
// Port checks of the user flow control channel.
// Assumes a bind to the top module and the single clock sys_clk.
`timescale 1ns/10ps
`include "ufc_params.svh"

module ufc_channel_sva #(
  parameter int LANES = `UFC_LANES
) (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic msgReq, // Request
  input wire logic txMsgReady, // Message ready
  input wire logic regularDataReady, // Regular ready
  input wire logic clock_compensation, // Priority op
  input wire logic channel_bonding, // Priority op
  input wire logic nfcBusy, // Priority op
  input wire logic linkReady, // Lane takes block
  input wire logic [1:0] txBlkKind, // Block kind
  input wire logic [`UFC_LANE_BYTES*LANES-1:0] txBlkKeep, // Block bytes
  input wire logic txBlkLast, // Final block
  input wire logic rxHdrValid, // Header in
  input wire logic [`UFC_SIZE_W-1:0] rxHdrSize, // Header size
  input wire logic rxDataValid, // Data in
  input wire logic rxMsgValid, // Word out
  input wire logic rxMsgLast, // Final word
  input wire logic [`UFC_LANE_BYTES*LANES-1:0] rxMsgKeep, // Word bytes
  input wire logic rxInProgressN // Receiving, active low
);
  wire hiPri = clock_compensation | channel_bonding | nfcBusy;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Transmit and receive relations
  // ----------------------------------------
  hdr_gap_a: assert property (regularDataReady ##1 msgReq
    |=> !txMsgReady && !regularDataReady)
    else $error("header cycle readies not low");
  ready_two_a: assert property (regularDataReady ##1 (msgReq && !hiPri && linkReady)
    ##1 (!hiPri && linkReady) |=> txMsgReady || hiPri)
    else $error("message ready late");
  ready_excl_a: assert property (txMsgReady |-> !regularDataReady)
    else $error("both readies high");
  prio_drop_a: assert property (hiPri |-> !txMsgReady)
    else $error("ready during priority op");
  tx_keep_a: assert property (txBlkKind == ufc_pkg::BLK_DATA && txBlkLast
    |-> txBlkKeep != '0 && (~txBlkKeep & (~txBlkKeep + 1'b1)) == '0)
    else $error("final tx keep not from top");
  rx_open_a: assert property (rxHdrValid |=> !rxInProgressN)
    else $error("progress flag not low");
  rx_single_a: assert property (rxHdrValid && rxHdrSize < 8
    ##1 rxDataValid && !rxHdrValid
    |=> rxMsgValid && rxMsgLast && rxInProgressN)
    else $error("single word not valid and last");
  rx_word_a: assert property (rxDataValid && !rxHdrValid && !rxInProgressN |=> rxMsgValid)
    else $error("received word missing");
  rx_cause_a: assert property (rxMsgValid |-> $past(rxDataValid))
    else $error("word without data block");
  rx_keep_a: assert property (rxMsgValid && rxMsgLast
    |-> rxMsgKeep != '0 && (~rxMsgKeep & (~rxMsgKeep + 1'b1)) == '0)
    else $error("final rx keep not from top");
  rx_full_a: assert property (rxMsgValid && !rxMsgLast |-> rxMsgKeep == '1)
    else $error("inner rx keep not full");

  cover property (rxMsgValid && rxMsgLast);
  cover property (txBlkKind == ufc_pkg::BLK_IDLE);
  cover property (hiPri && !txMsgReady ##1 txMsgReady);
endmodule

bind user_flow_control_channel ufc_channel_sva #(.LANES(LANES)) chk (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .msgReq(msgReq),
  .txMsgReady(txMsgReady),
  .regularDataReady(regularDataReady),
  .clock_compensation(clock_compensation),
  .channel_bonding(channel_bonding),
  .nfcBusy(nfcBusy),
  .linkReady(linkReady),
  .txBlkKind(txBlkKind),
  .txBlkKeep(txBlkKeep),
  .txBlkLast(txBlkLast),
  .rxHdrValid(rxHdrValid),
  .rxHdrSize(rxHdrSize),
  .rxDataValid(rxDataValid),
  .rxMsgValid(rxMsgValid),
  .rxMsgLast(rxMsgLast),
  .rxMsgKeep(rxMsgKeep),
  .rxInProgressN(rxInProgressN)
);

// [testbench/user_flow_control_channel_tb.sv]
// Self-checking bench of the user flow control channel.
// Assumes the application model and the bound port checker.
`timescale 1ns/10ps

module user_flow_control_channel_tb;
  logic sys_clk = 1'b0, resetn = 1'b0, msgReq = 1'b0, go = 1'b0;
  logic clock_compensation = 1'b0, channel_bonding = 1'b0, nfcBusy = 1'b0;
  logic linkReady = 1'b1, rxHdrValid = 1'b0, rxDataValid = 1'b0;
  logic [7:0] msg_size_code = 8'h00, rxHdrSize = 8'h00;
  logic [63:0] rxData = 64'h0000_0000_0000_0000;
  logic [63:0] txMsgData, txBlkData, rxMsgData;
  logic [7:0] txBlkKeep, rxMsgKeep;
  logic [1:0] txBlkKind;
  logic txMsgValid, txMsgReady, regularDataReady, txBlkLast, done;
  logic rxMsgValid, rxMsgLast, rxInProgressN;
  int beats = 0, gapAt = -1, fails = 0, checks_done = 0;
  logic [74:0] blkQ[$];

  user_flow_control_channel dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .msgReq(msgReq),
    .msg_size_code(msg_size_code),
    .txMsgData(txMsgData),
    .txMsgValid(txMsgValid),
    .txMsgReady(txMsgReady),
    .regularDataReady(regularDataReady),
    .clock_compensation(clock_compensation),
    .channel_bonding(channel_bonding),
    .nfcBusy(nfcBusy),
    .linkReady(linkReady),
    .txBlkKind(txBlkKind),
    .txBlkData(txBlkData),
    .txBlkKeep(txBlkKeep),
    .txBlkLast(txBlkLast),
    .rxHdrValid(rxHdrValid),
    .rxHdrSize(rxHdrSize),
    .rxDataValid(rxDataValid),
    .rxData(rxData),
    .rxMsgData(rxMsgData),
    .rxMsgValid(rxMsgValid),
    .rxMsgLast(rxMsgLast),
    .rxMsgKeep(rxMsgKeep),
    .rxInProgressN(rxInProgressN)
  );

  ufc_app_model app (
    .sys_clk(sys_clk),
    .go(go),
    .beats(beats),
    .gapAt(gapAt),
    .txMsgReady(txMsgReady),
    .txMsgValid(txMsgValid),
    .txMsgData(txMsgData),
    .done(done)
  );

  // Clock, 50 ns period
  initial forever #25 sys_clk = ~sys_clk;

  // Log each block the lane takes
  always @(posedge sys_clk)
    if (linkReady === 1'b1 && txBlkKind !== 2'b00)
      blkQ.push_back({txBlkKind, txBlkLast, txBlkKeep, txBlkData});

  function automatic logic [63:0] pat(input int n);
    return {8{8'(n + 1)}};
  endfunction

  task automatic chk(input string what, input logic [74:0] exp, input logic [74:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One message: request, optional gap, priority op or lane stall
  task automatic tx_msg(input logic [7:0] code, input int gap, input int prio, input bit stall);
    int n, i, k;
    logic [74:0] b;
    n = code / 8 + 1;
    blkQ.delete();
    beats = n;
    gapAt = gap;
    msgReq = 1'b1;
    msg_size_code = code;
    go = 1'b1;
    @(posedge sys_clk);
    #1 msgReq = 1'b0;
    chk("header readies", 2'b00, {txMsgReady, regularDataReady});
    @(posedge sys_clk);
    #1 chk("ready cycle two", 2'b10, {txMsgReady, regularDataReady});
    if (prio > 0)
    begin
      {clock_compensation, channel_bonding, nfcBusy} = 3'b100 >> (prio - 1);
      #1 chk("ready priority", 1'b0, txMsgReady);
      repeat (2) @(posedge sys_clk);
      #1 {clock_compensation, channel_bonding, nfcBusy} = 3'b000;
    end
    if (stall)
    begin
      linkReady = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1 chk("ready full", 1'b0, txMsgReady);
      linkReady = 1'b1;
    end
    for (i = 0; i < 200 && done !== 1'b1; i++)
      @(posedge sys_clk);
    #1 chk("message done", 1'b1, done);
    go = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 chk("regular ready", 1'b1, regularDataReady);
    b = blkQ.pop_front();
    chk("header block", {2'b01, 9'h000, 56'h0, code}, b);
    i = 0;
    k = 0;
    while (blkQ.size() > 0)
    begin
      b = blkQ.pop_front();
      if (b[74:73] === 2'b11)
        k++;
      else
      begin
        chk("data block", {2'b10, i == n - 1, i == n - 1 ? 8'hFF << (3'd7 - code[2:0])
          : 8'hFF, pat(i)}, b);
        i++;
      end
    end
    chk("beat count", n, i);
    chk("idle count", gap > 0, k);
  endtask

  // One received message, then a stray data block
  task automatic rx_msg(input logic [7:0] code);
    int n;
    n = code / 8 + 1;
    rxHdrValid = 1'b1;
    rxHdrSize = code;
    @(posedge sys_clk);
    #1 rxHdrValid = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      chk("in progress", 1'b0, rxInProgressN);
      rxDataValid = 1'b1;
      rxData = pat(i);
      @(posedge sys_clk);
      #1 chk("rx word", {1'b1, i == n - 1, i == n - 1 ? 8'hFF << (3'd7 - code[2:0]) : 8'hFF,
        pat(i)}, {rxMsgValid, rxMsgLast, rxMsgKeep, rxMsgData});
    end
    chk("done flag", 1'b1, rxInProgressN);
    rxData = ~rxData;
    @(posedge sys_clk);
    #1 chk("stray ignored", 1'b0, rxMsgValid);
    rxDataValid = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 chk("reset outputs", 3'b100, {rxInProgressN, txMsgReady, rxMsgValid});
    resetn = 1'b1;
    tx_msg(8'h03, -1, 0, 1'b0);
    tx_msg(8'h0F, 1, 0, 1'b0);
    tx_msg(8'h0E, -1, 1, 1'b0);
    tx_msg(8'h07, -1, 2, 1'b0);
    tx_msg(8'h17, -1, 3, 1'b0);
    tx_msg(8'hFF, -1, 0, 1'b1);
    rx_msg(8'h03);
    rx_msg(8'h0E);
    rx_msg(8'hFF);
    complete_run();
  end

  // Watchdog
  initial
  begin
    #500_000;
    fails++;
    complete_run();
  end
endmodule
